// *** rtl/sdc_decoder.sv ***
`default_nettype none

// Contract
// - Commands execute only at chip-select rise after the frame, never while shifting.
// - Dual supply variant, power down without load enable: load inputs, power down.
// - Dual variants, power down with immediate load: load, power down, update both.
// - Dual supply, all control bits set, strobe low: update immediately.
// - Dual supply, all bits set, strobe high: update on next strobe fall.
// - Dual external variant, load enable with no select updates both DAC registers.
// - Dual external, no power down, no load enable: load selected inputs only.
// - Dual external, load enable with selection: load then update both at rise.
// - Dual external, power down only: load and power down selected, DACs unchanged.
// - Single variant ignores select B; select A clear without load enable only cancels a pending strobe update.
// - Single variant, load enable, strobe not deferring: update DAC at chip-select rise.
// - Single variant, deferred load: update on first strobe fall after chip-select rise.
// - Single variant, power down only: load input, power down, DAC unchanged.
// - Single variant, power down with immediate load: load, power down, update DAC.
// - Single variant, all set, strobe high: power down, update on strobe fall.
// - DAC code is straight binary, one step is reference over 256.
// - Frame is MSB first: three spare bits, five control bits, data 7 to 0.
// - While chip select is low, data shifts in on each serial clock rise.
// - Reset clears input registers, DAC registers and control state.

module sdc_decoder #(
	parameter sdc_pkg::sdc_variant_e VARIANT = sdc_pkg::VAR_DUAL_SUPPLY
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic load_strobe_n,
	output logic [sdc_pkg::CODE_BITS-1:0] dac_code_a,
	output logic [sdc_pkg::CODE_BITS-1:0] dac_code_b,
	output logic power_down_a,
	output logic power_down_b,
	output logic update_armed,
	output logic frame_done
);

	localparam int CW = sdc_pkg::CODE_BITS;
	localparam int NC = sdc_pkg::NUM_CH;
	localparam bit HAS_STROBE = (VARIANT != sdc_pkg::VAR_DUAL_EXT);
	localparam bit IS_SINGLE = (VARIANT == sdc_pkg::VAR_SINGLE);

	// Serial clock domain: the shift register only.
	logic [sdc_pkg::FRAME_BITS-1:0] shift_reg;
	logic [sdc_pkg::FRAME_BITS-1:0] shift_next;

	always_comb begin
		shift_next = shift_reg;
		if (!cs_n) begin
			shift_next = {shift_reg[sdc_pkg::FRAME_BITS-2:0], sdi};
		end
	end

	always_ff @(posedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_reg <= sdc_pkg::RST_SHIFT;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// System clock domain: pin synchronisers with one extra stage for edge detection.
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic st_s1_reg, st_s2_reg, st_s3_reg;
	logic cs_s1_next, cs_s2_next, cs_s3_next;
	logic st_s1_next, st_s2_next, st_s3_next;

	always_comb begin
		cs_s1_next = cs_n;
		cs_s2_next = cs_s1_reg;
		cs_s3_next = cs_s2_reg;
		st_s1_next = load_strobe_n;
		st_s2_next = st_s1_reg;
		st_s3_next = st_s2_reg;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_s1_reg <= sdc_pkg::RST_PIN_IDLE;
			cs_s2_reg <= sdc_pkg::RST_PIN_IDLE;
			cs_s3_reg <= sdc_pkg::RST_PIN_IDLE;
			st_s1_reg <= sdc_pkg::RST_PIN_IDLE;
			st_s2_reg <= sdc_pkg::RST_PIN_IDLE;
			st_s3_reg <= sdc_pkg::RST_PIN_IDLE;
		end else begin
			cs_s1_reg <= cs_s1_next;
			cs_s2_reg <= cs_s2_next;
			cs_s3_reg <= cs_s3_next;
			st_s1_reg <= st_s1_next;
			st_s2_reg <= st_s2_next;
			st_s3_reg <= st_s3_next;
		end
	end

	// The shift register is read here only after chip select has been high for two
	// system clocks; the serial clock is idle by then, so the word is stable. The host
	// must therefore keep chip select high for at least three system clocks.
	logic exec;
	logic strobe_fall;
	logic strobe_high;
	logic [sdc_pkg::FRAME_BITS-1:0] word;
	logic pwr_bit, load_en_bit, on_strobe_bit;
	logic [NC-1:0] sel;
	logic [CW-1:0] data;
	logic cmd_valid;
	logic defer;

	always_comb begin
		exec = cs_s2_reg & ~cs_s3_reg;
		strobe_fall = st_s3_reg & ~st_s2_reg;
		strobe_high = st_s2_reg;
		word = shift_reg;
		pwr_bit = word[sdc_pkg::POS_POWER_DOWN];
		load_en_bit = word[sdc_pkg::POS_DAC_LOAD_EN];
		on_strobe_bit = word[sdc_pkg::POS_LOAD_ON_STROBE];
		sel[0] = word[sdc_pkg::POS_SELECT_A];
		sel[1] = IS_SINGLE ? 1'b0 : word[sdc_pkg::POS_SELECT_B];
		data = word[sdc_pkg::POS_DATA_MSB:sdc_pkg::POS_DATA_LSB];
		// No selection is only meaningful as a plain update; the external-reference
		// variant also accepts it with the power down bit set.
		cmd_valid = (sel != '0) || (load_en_bit && !pwr_bit)
			|| (!HAS_STROBE && load_en_bit);
		defer = HAS_STROBE && on_strobe_bit && strobe_high;
	end

	logic [NC-1:0][CW-1:0] in_reg, in_next;
	logic [NC-1:0][CW-1:0] dac_reg, dac_next;
	logic [NC-1:0] pd_reg, pd_next;
	logic armed_reg, armed_next;
	logic done_reg, done_next;

	always_comb begin
		in_next = in_reg;
		dac_next = dac_reg;
		pd_next = pd_reg;
		armed_next = armed_reg;
		done_next = 1'b0;
		if (exec) begin
			// A new command disarms any pending strobe update, even if it is unassigned.
			armed_next = 1'b0;
			done_next = 1'b1;
			if (cmd_valid) begin
				for (int i = 0; i < NC; i++) begin
					if (sel[i]) begin
						in_next[i] = data;
						pd_next[i] = pwr_bit;
					end
				end
				if (load_en_bit) begin
					if (defer) begin
						armed_next = 1'b1;
					end else begin
						dac_next = in_next;
					end
				end
			end
		end else if (armed_reg && strobe_fall) begin
			dac_next = in_reg;
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_reg <= {NC{sdc_pkg::RST_CODE}};
			dac_reg <= {NC{sdc_pkg::RST_CODE}};
			pd_reg <= {NC{sdc_pkg::RST_POWER_DOWN}};
			armed_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			in_reg <= in_next;
			dac_reg <= dac_next;
			pd_reg <= pd_next;
			armed_reg <= armed_next;
			done_reg <= done_next;
		end
	end

	// The code leaves as plain binary; the ladder scales it by reference over 256.
	assign dac_code_a = dac_reg[0];
	assign dac_code_b = dac_reg[1];
	assign power_down_a = pd_reg[0];
	assign power_down_b = pd_reg[1];
	assign update_armed = armed_reg;
	assign frame_done = done_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_arm;
		exec && cmd_valid && load_en_bit && defer;
	endsequence

	sequence s_fire;
		!exec && armed_reg && strobe_fall;
	endsequence

	property p_hold_between;
		(!exec && !(armed_reg && strobe_fall)) |=> ($stable(dac_reg) && $stable(in_reg)
			&& $stable(pd_reg));
	endproperty
	a_hold_between: assert property (p_hold_between)
		else $error("registers changed without a command or strobe");

	property p_load_a;
		(exec && cmd_valid && sel[0]) |=> (in_reg[0] == $past(data)
			&& pd_reg[0] == $past(pwr_bit));
	endproperty
	a_load_a: assert property (p_load_a)
		else $error("channel A input or power state not taken from frame");

	property p_unsel_keep;
		(exec && !sel[1]) |=> ($stable(in_reg[1]) && $stable(pd_reg[1]));
	endproperty
	a_unsel_keep: assert property (p_unsel_keep)
		else $error("unselected channel B changed");

	property p_immediate;
		(exec && cmd_valid && load_en_bit && !defer) |=> (dac_reg == in_reg && !armed_reg);
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("immediate update did not copy inputs");

	property p_no_load_en;
		(exec && !load_en_bit) |=> $stable(dac_reg);
	endproperty
	a_no_load_en: assert property (p_no_load_en)
		else $error("DAC register changed without load enable");

	property p_defer;
		s_arm |=> (armed_reg && $stable(dac_reg)) ##1 (armed_reg || $past(strobe_fall)
			|| $past(exec));
	endproperty
	a_defer: assert property (p_defer)
		else $error("deferred update not armed");

	property p_fire;
		s_fire |=> (!armed_reg && dac_reg == $past(in_reg));
	endproperty
	a_fire: assert property (p_fire)
		else $error("strobe fall did not perform armed update");

	property p_unassigned;
		(exec && !cmd_valid) |=> ($stable(in_reg) && $stable(dac_reg) && $stable(pd_reg)
			&& !armed_reg);
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned command had an effect");

	property p_ext_never_arms;
		!HAS_STROBE |-> !armed_reg;
	endproperty
	a_ext_never_arms: assert property (p_ext_never_arms)
		else $error("external reference variant armed a strobe update");

	property p_single_b_idle;
		IS_SINGLE |-> (dac_reg[1] == sdc_pkg::RST_CODE && !pd_reg[1]);
	endproperty
	a_single_b_idle: assert property (p_single_b_idle)
		else $error("single variant touched channel B");

	property p_done_pulse;
		exec |=> frame_done ##1 !frame_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("frame done pulse malformed");

endmodule // sdc_decoder

`default_nettype wire

// *** rtl/sdc_pkg.sv ***
`default_nettype none

package sdc_pkg;

	// Which member of the family the decoder behaves as.
	typedef enum logic [1:0] {
		VAR_DUAL_SUPPLY = 2'b00,
		VAR_DUAL_EXT = 2'b01,
		VAR_SINGLE = 2'b10
	} sdc_variant_e;

	localparam int FRAME_BITS = 16;
	localparam int CODE_BITS = 8;
	localparam int NUM_CH = 2;

	// Bit positions inside the 16-bit frame, first bit shifted in is bit 15.
	localparam int POS_UNASSIGNED_FIRST = 15;
	localparam int POS_POWER_DOWN = 12;
	localparam int POS_DAC_LOAD_EN = 11;
	localparam int POS_LOAD_ON_STROBE = 10;
	localparam int POS_SELECT_B = 9;
	localparam int POS_SELECT_A = 8;
	localparam int POS_DATA_MSB = 7;
	localparam int POS_DATA_LSB = 0;

	// Values after reset.
	localparam logic [FRAME_BITS-1:0] RST_SHIFT = 16'h0000;
	localparam logic [CODE_BITS-1:0] RST_CODE = 8'h00;
	localparam logic RST_POWER_DOWN = 1'b0;
	localparam logic RST_PIN_IDLE = 1'b1;

	// Synchroniser length for pins entering the system clock domain.
	localparam int SYNC_STAGES = 2;

endpackage : sdc_pkg

`default_nettype wire

// *** tb/sdc_host.sv ***
`default_nettype none

// Host serial master; the clock exists only inside a frame and data moves on its falling side.
module sdc_host (
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	task automatic send(input logic [15:0] w);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi = w[i];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		// The line is released, so it must not keep showing the last bit.
		sdi = ~w[0];
	endtask
endmodule // sdc_host

`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, sys_rst, load_strobe_n, sclk, cs_n, sdi, pd_a, pd_b, armed;
	logic [7:0] code_a, code_b, code_s;
	logic frame_pulse, pd_s, pd_xa, pd_xb, armed_x;
	logic [7:0] code_xa, code_xb;
	logic [15:0] done_seen = 16'h0000;
	int bad_count = 0;
	int checked = 0;

	sdc_host i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
	sdc_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.load_strobe_n(load_strobe_n), .dac_code_a(code_a), .dac_code_b(code_b),
		.power_down_a(pd_a), .power_down_b(pd_b), .update_armed(armed),
		.frame_done(frame_pulse));
	sdc_decoder #(.VARIANT(sdc_pkg::VAR_SINGLE)) i_dut_single (.clk(clk), .sys_rst(sys_rst),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .load_strobe_n(load_strobe_n),
		.dac_code_a(code_s), .dac_code_b(), .power_down_a(pd_s), .power_down_b(),
		.update_armed(), .frame_done());
	sdc_decoder #(.VARIANT(sdc_pkg::VAR_DUAL_EXT)) i_dut_ext (.clk(clk), .sys_rst(sys_rst),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .load_strobe_n(load_strobe_n),
		.dac_code_a(code_xa), .dac_code_b(code_xb), .power_down_a(pd_xa),
		.power_down_b(pd_xb), .update_armed(armed_x), .frame_done());

	// The pulse lasts one system clock, so the falling edge sees each one exactly once.
	always @(negedge clk) begin
		if (frame_pulse === 1'b1) begin
			done_seen = done_seen + 16'h0001;
		end
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic expect_state(input logic [7:0] a, b, input logic [2:0] st,
		input logic [7:0] s);
		logic [26:0] got;
		logic [26:0] exp;
		got = {code_a, code_b, pd_a, pd_b, armed, code_s};
		exp = {a, b, st, s};
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic expect_ext(input logic [7:0] a, b, input logic [2:0] st, input logic ps);
		logic [19:0] got;
		logic [19:0] exp;
		got = {code_xa, code_xb, pd_xa, pd_xb, armed_x, pd_s};
		exp = {a, b, st, ps};
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic expect_count(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Eight cycles after the frame leave room for the synchroniser and the gap between frames.
	task automatic frame(input logic [15:0] w);
		@(negedge clk);
		#7 i_host.send(w);
		repeat (8) @(negedge clk);
	endtask

	task automatic strobe(input logic v);
		@(negedge clk);
		load_strobe_n = v;
		repeat (6) @(negedge clk);
	endtask

	task automatic sc_load_update();
		frame(16'h0155);
		expect_state(8'h00, 8'h00, 3'h0, 8'h00);
		frame(16'h0800);
		expect_state(8'h55, 8'h00, 3'h0, 8'h55);
	endtask

	task automatic sc_power();
		frame(16'h12AA);
		expect_state(8'h55, 8'h00, 3'h2, 8'h55);
		frame(16'h1B33);
		expect_state(8'h33, 8'h33, 3'h6, 8'h33);
		frame(16'h0344);
		expect_state(8'h33, 8'h33, 3'h0, 8'h33);
	endtask

	task automatic sc_deferred();
		frame(16'h1D77);
		expect_state(8'h33, 8'h33, 3'h5, 8'h33);
		strobe(1'b0);
		expect_state(8'h77, 8'h44, 3'h4, 8'h77);
	endtask

	task automatic sc_immediate();
		frame(16'h1E88);
		expect_state(8'h77, 8'h88, 3'h6, 8'h77);
		strobe(1'b1);
	endtask

	task automatic sc_disarm();
		frame(16'h1D99);
		expect_state(8'h77, 8'h88, 3'h7, 8'h77);
		frame(16'h0000);
		expect_state(8'h77, 8'h88, 3'h6, 8'h77);
		strobe(1'b0);
		expect_state(8'h77, 8'h88, 3'h6, 8'h77);
		strobe(1'b1);
	endtask

	// The external-reference instance has seen every frame so far and never defers.
	task automatic sc_ext();
		expect_ext(8'h99, 8'h88, 3'h6, 1'b1);
		frame(16'h0A11);
		expect_state(8'h99, 8'h11, 3'h4, 8'h99);
		expect_ext(8'h99, 8'h11, 3'h4, 1'b1);
		frame(16'h0322);
		expect_state(8'h99, 8'h11, 3'h0, 8'h99);
		expect_ext(8'h99, 8'h11, 3'h0, 1'b0);
		frame(16'h1C00);
		expect_state(8'h99, 8'h11, 3'h0, 8'h99);
		expect_ext(8'h22, 8'h22, 3'h0, 1'b0);
		frame(16'h1155);
		expect_state(8'h99, 8'h11, 3'h4, 8'h99);
		expect_ext(8'h22, 8'h22, 3'h4, 1'b1);
		expect_count(done_seen, 16'h000D);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#200us;
		bad_count++;
		report_and_stop();
	end

	initial begin
		// Reset rises after time zero so that every reset branch sees a clean edge.
		sys_rst = 1'b0;
		load_strobe_n = 1'b1;
		#1 sys_rst = 1'b1;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		expect_state(8'h00, 8'h00, 3'h0, 8'h00);
		sc_load_update();
		sc_power();
		sc_deferred();
		sc_immediate();
		sc_disarm();
		sc_ext();
		report_and_stop();
	end
endmodule // tb_top

`default_nettype wire
